// ### rtl/bwcl_loader.v
`timescale 1ns/10ps
`default_nettype none
`include "bwcl_defines.vh"
module bwcl_loader (
	// clock and reset
	input wire clk,
	input wire rst_n,
	// configuration clock and mode straps (pins)
	input wire config_clock,
	input wire mode_select_bit2,
	input wire mode_select_bit1,
	input wire mode_select_bit0,
	// init and done levels (pins)
	input wire init_in,
	input wire config_done,
	// variant strap: upper lines fixed active (pin)
	input wire fixed_upper_lines,
	// byte-wide data (pins)
	input wire [7:0] config_byte_in,
	// from configuration core, same clock
	input wire wide_address_request,
	input wire chain_forward,
	// prom address outputs
	output wire [17:0] prom_address,
	output wire prom_address_oe_n,
	output wire [3:0] upper_prom_address,
	output wire upper_prom_address_oe_n,
	// peripheral acknowledge
	output wire byte_ack,
	// chain serial output
	output wire chain_dout,
	// bit stream to own core
	output wire core_bit,
	output wire core_bit_strobe,
	// status
	output wire loading,
	output wire capture_overrun
);
	localparam ST_IDLE = 4'b0001;
	localparam ST_MASTER = 4'b0010;
	localparam ST_PERIPH = 4'b0100;
	localparam ST_DONE = 4'b1000;

	wire [`BWCL_SYNC_W-1:0] sync_in;
	wire [`BWCL_SYNC_W-1:0] sync_out;
	wire config_clock_s;
	wire [2:0] mode_s;
	wire init_s;
	wire done_s;
	wire fixed_s;
	wire [7:0] byte_s;

	reg config_clock_d;
	reg init_d;
	wire rise;
	wire fall;
	wire init_rise;

	reg [3:0] state;
	reg [3:0] next_state;
	reg count_down;
	reg fixed_upper;
	reg wide_req;
	wire upper_active;

	reg [`BWCL_ADDR_W-1:0] addr;
	reg [`BWCL_ADDR_W-1:0] next_addr;
	reg [2:0] rise_count;
	reg addr_oe_n;
	reg upper_oe_n;
	reg ack;
	reg overrun;

	wire capture_slot;
	wire fifo_in_valid;
	wire fifo_in_ready;
	wire fifo_out_valid;
	wire fifo_out_ready;
	wire [7:0] fifo_out_data;

	reg [7:0] sh_reg;
	reg [3:0] sh_count;
	reg dout;
	reg cbit;
	reg cstrobe;
	wire load_master;
	wire load_periph;

	// pins pass two flops; data and clock share latency so byte and edge stay aligned
	assign sync_in = {config_clock, mode_select_bit2, mode_select_bit1, mode_select_bit0,
		init_in, config_done, fixed_upper_lines, config_byte_in};

	bwcl_sync #(
		.W(`BWCL_SYNC_W)
	) u_sync (
		.clk(clk),
		.rst_n(rst_n),
		.d(sync_in),
		.q(sync_out)
	);

	assign config_clock_s = sync_out[14];
	assign mode_s = sync_out[13:11];
	assign init_s = sync_out[10];
	assign done_s = sync_out[9];
	assign fixed_s = sync_out[8];
	assign byte_s = sync_out[7:0];

	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			config_clock_d <= 1'b0;
			init_d <= 1'b0;
		end else begin
			config_clock_d <= config_clock_s;
			init_d <= init_s;
		end
	end

	assign rise = config_clock_s && !config_clock_d;
	assign fall = !config_clock_s && config_clock_d;
	assign init_rise = init_s && !init_d;

	always @* begin
		next_state = state;
		case (state)
			ST_IDLE: begin
				if (init_rise) begin
					if (mode_s == `BWCL_MODE_MASTER_UP || mode_s == `BWCL_MODE_MASTER_DOWN) begin
						next_state = ST_MASTER;
					end else if (mode_s == `BWCL_MODE_SYNC_PERIPH) begin
						next_state = ST_PERIPH;
					end
				end
			end
			ST_MASTER: begin
				if (done_s) begin
					next_state = ST_DONE;
				end
			end
			ST_PERIPH: begin
				if (done_s) begin
					next_state = ST_DONE;
				end
			end
			ST_DONE: begin
				if (!init_s) begin
					next_state = ST_IDLE;
				end
			end
			default: begin
				next_state = ST_IDLE;
			end
		endcase
	end

	// straps are caught by the clock at the start of a load, never by reset
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			state <= ST_IDLE;
			count_down <= 1'b0;
			fixed_upper <= 1'b0;
		end else begin
			state <= next_state;
			if (state == ST_IDLE && init_rise) begin
				count_down <= (mode_s == `BWCL_MODE_MASTER_DOWN);
				fixed_upper <= fixed_s;
			end
		end
	end

	// the stream request is sticky for the rest of the load
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			wide_req <= 1'b0;
		end else if (state == ST_IDLE) begin
			wide_req <= 1'b0;
		end else if (wide_address_request) begin
			wide_req <= 1'b1;
		end
	end

	assign upper_active = fixed_upper || wide_req;

	// capture slot every eighth rise, or again next rise in master mode while the fifo is full, the first at an offset set per mode
	assign capture_slot = rise && (rise_count == 3'h0) && (state == ST_MASTER || state == ST_PERIPH);
	assign fifo_in_valid = capture_slot;

	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rise_count <= `BWCL_MASTER_FIRST;
		end else if (next_state == ST_MASTER && state == ST_IDLE) begin
			rise_count <= `BWCL_MASTER_FIRST;
		end else if (next_state == ST_PERIPH && state == ST_IDLE) begin
			rise_count <= `BWCL_PERIPH_FIRST;
		end else if (rise) begin
			if (rise_count != 3'h0) begin
				rise_count <= rise_count - 3'h1;
			end else if (fifo_in_ready || state == ST_PERIPH) begin
				rise_count <= `BWCL_BYTE_RISES;
			end
		end
	end

	always @* begin
		next_addr = addr;
		if (upper_active) begin
			if (count_down) begin
				next_addr = addr - `BWCL_FULL_ONE;
			end else begin
				next_addr = addr + `BWCL_FULL_ONE;
			end
		end else if (count_down) begin
			next_addr = {addr[21:18], addr[17:0] - `BWCL_LOW_ONE};
		end else begin
			next_addr = {addr[21:18], addr[17:0] + `BWCL_LOW_ONE};
		end
	end

	// a full fifo holds the address so the byte is read again next rise
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			addr <= `BWCL_ADDR_UP_START;
		end else if (state == ST_IDLE && init_rise) begin
			if (mode_s == `BWCL_MODE_MASTER_DOWN) begin
				addr <= `BWCL_ADDR_DOWN_START;
			end else begin
				addr <= `BWCL_ADDR_UP_START;
			end
		end else if (state == ST_MASTER && capture_slot && fifo_in_ready) begin
			addr <= next_addr;
		end
	end

	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			addr_oe_n <= 1'b1;
			upper_oe_n <= 1'b1;
		end else begin
			addr_oe_n <= !(next_state == ST_MASTER);
			// at load start the latched strap is still the old one, so read it directly
			upper_oe_n <= !(next_state == ST_MASTER && (state == ST_IDLE ? fixed_s : upper_active));
		end
	end

	// the host cannot be stalled, so a lost peripheral byte is only flagged
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			ack <= 1'b0;
			overrun <= 1'b0;
		end else begin
			if (state == ST_IDLE && init_rise) begin
				overrun <= 1'b0;
			end else if (state == ST_PERIPH && capture_slot && !fifo_in_ready) begin
				overrun <= 1'b1;
			end
			if (state == ST_PERIPH && capture_slot) begin
				ack <= 1'b1;
			end else if (rise) begin
				ack <= 1'b0;
			end
		end
	end

	bwcl_fifo #(
		.WIDTH(`BWCL_BYTE_W),
		.DEPTH(`BWCL_FIFO_DEPTH),
		.AW(`BWCL_FIFO_AW)
	) u_fifo (
		.clk(clk),
		.rst_n(rst_n),
		.in_valid(fifo_in_valid),
		.in_ready(fifo_in_ready),
		.in_data(byte_s),
		.out_valid(fifo_out_valid),
		.out_ready(fifo_out_ready),
		.out_data(fifo_out_data)
	);

	// master loads on the rise after capture, peripheral on the fall right after it
	assign load_master = (state == ST_MASTER) && rise && fifo_out_valid && (sh_count == 4'h0);
	assign load_periph = (state == ST_PERIPH) && fall && fifo_out_valid && (sh_count == 4'h0);
	// idle drains leftovers so a new load never shifts a stale byte
	assign fifo_out_ready = load_master || load_periph || (state == ST_IDLE);

	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			sh_reg <= 8'h00;
			sh_count <= `BWCL_BITS_NONE;
			dout <= `BWCL_DOUT_IDLE;
			cbit <= 1'b0;
			cstrobe <= 1'b0;
		end else begin
			cstrobe <= 1'b0;
			if (state == ST_IDLE) begin
				sh_count <= `BWCL_BITS_NONE;
			end else if (load_master) begin
				sh_reg <= fifo_out_data;
				sh_count <= `BWCL_BITS_FULL;
			end else if (load_periph) begin
				sh_reg <= {1'b0, fifo_out_data[7:1]};
				sh_count <= `BWCL_BITS_AFTER_FIRST;
				cbit <= fifo_out_data[0];
				cstrobe <= !chain_forward;
				if (chain_forward) begin
					dout <= fifo_out_data[0];
				end
			end else if (fall && sh_count != 4'h0) begin
				sh_reg <= {1'b0, sh_reg[7:1]};
				sh_count <= sh_count - 4'h1;
				cbit <= sh_reg[0];
				cstrobe <= !chain_forward;
				if (chain_forward) begin
					dout <= sh_reg[0];
				end
			end
		end
	end

	assign prom_address = addr[17:0];
	assign upper_prom_address = addr[21:18];
	assign prom_address_oe_n = addr_oe_n;
	assign upper_prom_address_oe_n = upper_oe_n;
	assign byte_ack = ack;
	assign chain_dout = dout;
	assign core_bit = cbit;
	assign core_bit_strobe = cstrobe;
	assign loading = (state == ST_MASTER) || (state == ST_PERIPH);
	assign capture_overrun = overrun;
endmodule
`default_nettype wire

// ### inc/bwcl_defines.vh
`ifndef BWCL_DEFINES_VH
`define BWCL_DEFINES_VH

`define BWCL_MODE_MASTER_UP 3'h4
`define BWCL_MODE_MASTER_DOWN 3'h6
`define BWCL_MODE_SYNC_PERIPH 3'h3

`define BWCL_ADDR_W 22
`define BWCL_LOW_ADDR_W 18
`define BWCL_UP_ADDR_W 4
`define BWCL_ADDR_UP_START 22'h000000
`define BWCL_ADDR_DOWN_START 22'h3fffff
`define BWCL_LOW_ONE 18'h00001
`define BWCL_FULL_ONE 22'h000001

`define BWCL_BYTE_W 8
`define BWCL_FIFO_DEPTH 8
`define BWCL_FIFO_AW 3

`define BWCL_BYTE_RISES 3'h7
`define BWCL_MASTER_FIRST 3'h0
`define BWCL_PERIPH_FIRST 3'h1
`define BWCL_BITS_FULL 4'h8
`define BWCL_BITS_AFTER_FIRST 4'h7
`define BWCL_BITS_NONE 4'h0

`define BWCL_SYNC_W 15
`define BWCL_DOUT_IDLE 1'h1

`endif

// ### rtl/bwcl_sync.v
`timescale 1ns/10ps
`default_nettype none
module bwcl_sync #(
	parameter W = 1
) (
	// clock and reset
	input wire clk,
	input wire rst_n,
	// asynchronous in, synchronised out
	input wire [W-1:0] d,
	output wire [W-1:0] q
);
	reg [W-1:0] meta;
	reg [W-1:0] stable;

	// meta feeds only the second stage
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			meta <= {W{1'b0}};
			stable <= {W{1'b0}};
		end else begin
			meta <= d;
			stable <= meta;
		end
	end

	assign q = stable;
endmodule
`default_nettype wire

// ### rtl/bwcl_fifo.v
`timescale 1ns/10ps
`default_nettype none
module bwcl_fifo #(
	parameter WIDTH = 8,
	parameter DEPTH = 8,
	parameter AW = 3
) (
	// clock and reset
	input wire clk,
	input wire rst_n,
	// fill side
	input wire in_valid,
	output wire in_ready,
	input wire [WIDTH-1:0] in_data,
	// drain side
	output wire out_valid,
	input wire out_ready,
	output wire [WIDTH-1:0] out_data
);
	reg [WIDTH-1:0] mem [0:DEPTH-1];
	reg [AW:0] wr_ptr;
	reg [AW:0] rd_ptr;
	wire full;
	wire empty;
	wire push;
	wire pop;

	assign empty = (wr_ptr == rd_ptr);
	assign full = (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]) && (wr_ptr[AW] != rd_ptr[AW]);
	assign in_ready = !full;
	assign out_valid = !empty;
	assign push = in_valid && !full;
	assign pop = out_ready && !empty;
	assign out_data = mem[rd_ptr[AW-1:0]];

	// storage has no reset; contents are only read behind a valid pointer
	always @(posedge clk) begin
		if (push) begin
			mem[wr_ptr[AW-1:0]] <= in_data;
		end
	end

	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			wr_ptr <= {(AW+1){1'b0}};
			rd_ptr <= {(AW+1){1'b0}};
		end else begin
			if (push) begin
				wr_ptr <= wr_ptr + {{AW{1'b0}}, 1'b1};
			end
			if (pop) begin
				rd_ptr <= rd_ptr + {{AW{1'b0}}, 1'b1};
			end
		end
	end
endmodule
`default_nettype wire

// ### dv/bwcl_loader_properties.sv
`timescale 1ns/10ps
`default_nettype none
module bwcl_loader_properties (
	// clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// pins in
	input wire logic config_clock,
	input wire logic mode_select_bit1,
	input wire logic fixed_upper_lines,
	// pins out
	input wire logic [17:0] prom_address,
	input wire logic prom_address_oe_n,
	input wire logic upper_prom_address_oe_n,
	input wire logic byte_ack,
	input wire logic chain_dout,
	input wire logic core_bit_strobe
);
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_n);
	property p_step;
		!prom_address_oe_n && $past(!prom_address_oe_n) && $changed(prom_address)
			|=> $stable(prom_address)[*8];
	endproperty
	a_step: assert property (p_step) else $error("address step too soon");
	property p_dir;
		!prom_address_oe_n && $past(!prom_address_oe_n) && $changed(prom_address)
			|-> prom_address - $past(prom_address) == (mode_select_bit1 ? 18'h3ffff : 18'h1);
	endproperty
	a_dir: assert property (p_dir) else $error("address step wrong");
	property p_ack;
		$rose(byte_ack) |-> byte_ack[*8] ##1 !byte_ack;
	endproperty
	a_ack: assert property (p_ack) else $error("ack length wrong");
	property p_ack_mode;
		byte_ack |-> prom_address_oe_n;
	endproperty
	a_ack_mode: assert property (p_ack_mode) else $error("ack in master mode");
	// two samples back lands inside the low half of the link clock
	property p_dout;
		$changed(chain_dout) |-> !$past(config_clock, 2);
	endproperty
	a_dout: assert property (p_dout) else $error("chain out moved off a fall");
	property p_fixed;
		fixed_upper_lines && !prom_address_oe_n |-> !upper_prom_address_oe_n;
	endproperty
	a_fixed: assert property (p_fixed) else $error("fixed upper lines idle");
	property p_dflt;
		!fixed_upper_lines && $fell(prom_address_oe_n) |-> upper_prom_address_oe_n;
	endproperty
	a_dflt: assert property (p_dflt) else $error("upper lines driven at start");
	property p_strobe;
		core_bit_strobe |=> (!core_bit_strobe)[*7];
	endproperty
	a_strobe: assert property (p_strobe) else $error("core bits too close");
	c_ack: cover property ($rose(byte_ack));
	c_down: cover property (!prom_address_oe_n && mode_select_bit1);
	c_core: cover property (core_bit_strobe);
endmodule
bind bwcl_loader bwcl_loader_properties u_props (
	.clk(clk),
	.rst_n(rst_n),
	.config_clock(config_clock),
	.mode_select_bit1(mode_select_bit1),
	.fixed_upper_lines(fixed_upper_lines),
	.prom_address(prom_address),
	.prom_address_oe_n(prom_address_oe_n),
	.upper_prom_address_oe_n(upper_prom_address_oe_n),
	.byte_ack(byte_ack),
	.chain_dout(chain_dout),
	.core_bit_strobe(core_bit_strobe)
);
`default_nettype wire

// ### dv/bwcl_prom_model.sv
`timescale 1ns/10ps
`default_nettype none
module bwcl_prom_model (
	// link
	input wire logic config_clock,
	input wire logic init_in,
	input wire logic host_mode,
	input wire logic [7:0] key,
	// prom address
	input wire logic [17:0] prom_address,
	input wire logic prom_address_oe_n,
	// data
	output logic [7:0] config_byte_in
);
	int rises = 0;
	logic [7:0] hbyte = 8'h00;
	logic [7:0] last = 8'h00;
	always @(posedge config_clock)
		rises <= init_in ? rises + 1 : 0;
	// byte set half a period before its slot, scrambled once hold is over
	always @(negedge config_clock) begin
		if (rises % 8 == 1)
			hbyte <= key ^ 8'(rises / 8);
		else if (rises % 8 == 2)
			hbyte <= ~hbyte;
	end
	always @(prom_address)
		if (!prom_address_oe_n)
			last = key ^ prom_address[7:0];
	// unselected prom shows the inverse of its last byte
	assign config_byte_in = host_mode ? hbyte :
		prom_address_oe_n ? ~last : key ^ prom_address[7:0];
endmodule
`default_nettype wire

// ### dv/bwcl_loader_test.sv
`timescale 1ns/10ps
`default_nettype none
module bwcl_loader_test;
	logic clk = 0, rst_n = 0, config_clock = 0, init_in = 0, config_done = 0;
	logic fixed_upper_lines = 0, wide_address_request = 0, chain_forward = 1;
	logic [2:0] mode = 3'h0;
	logic [7:0] key = 8'h00;
	logic [2:0] modes [3] = '{3'h4, 3'h6, 3'h3};
	int n_errors = 0, n_compared = 0, n_ack = 0;
	wire [7:0] config_byte_in;
	wire [17:0] prom_address;
	wire [3:0] upper_prom_address;
	wire prom_address_oe_n, upper_prom_address_oe_n, byte_ack, chain_dout;
	wire core_bit, core_bit_strobe, loading, capture_overrun;
	bwcl_loader uut (.clk(clk), .rst_n(rst_n), .config_clock(config_clock),
		.mode_select_bit2(mode[2]), .mode_select_bit1(mode[1]), .mode_select_bit0(mode[0]),
		.init_in(init_in), .config_done(config_done), .fixed_upper_lines(fixed_upper_lines),
		.config_byte_in(config_byte_in), .wide_address_request(wide_address_request),
		.chain_forward(chain_forward), .prom_address(prom_address),
		.prom_address_oe_n(prom_address_oe_n), .upper_prom_address(upper_prom_address),
		.upper_prom_address_oe_n(upper_prom_address_oe_n), .byte_ack(byte_ack),
		.chain_dout(chain_dout), .core_bit(core_bit), .core_bit_strobe(core_bit_strobe),
		.loading(loading), .capture_overrun(capture_overrun));
	bwcl_prom_model prom (.config_clock(config_clock), .init_in(init_in),
		.host_mode(mode == 3'h3), .key(key), .prom_address(prom_address),
		.prom_address_oe_n(prom_address_oe_n), .config_byte_in(config_byte_in));
	always #25 clk = ~clk;
	// free running and phase shifted; also gives the trailing pulses
	initial #7 forever #200 config_clock = ~config_clock;
	always @(posedge byte_ack) n_ack++;
	function automatic logic [7:0] exp_byte(input logic [2:0] m, input logic [7:0] k, input int n);
		logic [17:0] a;
		a = (m == 3'h6) ? 18'h3ffff - 18'(n) : 18'(n);
		return k ^ a[7:0];
	endfunction
	task automatic check(input string what, input logic [17:0] exp, input logic [17:0] got);
		n_compared++;
		if (got !== exp) begin
			n_errors++;
			$display("Error %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic final_report();
		$display("compared %0d mismatches %0d", n_compared, n_errors);
		if (n_errors == 0 && n_compared > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	task automatic run_test(input logic [2:0] m, input int nb);
		logic [7:0] b;
		logic ok;
		ok = m == 3'h4 || m == 3'h6 || m == 3'h3;
		@(posedge clk);
		key <= 8'($urandom);
		chain_forward <= 1'($urandom);
		fixed_upper_lines <= 1'($urandom);
		mode <= m;
		n_ack = 0;
		// start just after a fall so the first rise is unambiguous
		@(negedge config_clock);
		@(posedge clk);
		init_in <= 1'b1;
		repeat (6) @(negedge clk);
		check("loading", ok, loading);
		check("oe_n", !m[2] || !ok, prom_address_oe_n);
		if (ok && m[2]) begin
			check("start", m[1] ? 18'h3ffff : 18'h0, prom_address);
			check("upper oe_n", !fixed_upper_lines, upper_prom_address_oe_n);
			if (fixed_upper_lines)
				check("upper", {4{m[1]}}, upper_prom_address);
		end
		@(posedge clk);
		wide_address_request <= 1'($urandom);
		// each bit is taken on the rise where a downstream device would take it
		for (int k = 1; ok && k < 2 + 8 * nb; k++) begin
			@(posedge config_clock);
			b = exp_byte(m, key, (k - 2) / 8);
			if (k >= 2)
				check("bit", b[(k - 2) % 8], chain_forward ? chain_dout : core_bit);
		end
		repeat (4) @(negedge clk);
		check("acks", ok && !m[2] ? nb + 1 : 0, n_ack);
		check("overrun", 0, capture_overrun);
		@(posedge clk);
		config_done <= 1'b1;
		wide_address_request <= 1'b0;
		repeat (4) @(posedge clk);
		init_in <= 1'b0;
		repeat (8) @(negedge clk);
		check("idle", 1, {!loading, prom_address_oe_n} == 2'h3);
		@(posedge clk);
		config_done <= 1'b0;
		$display("test mode %h done", m);
	endtask
	initial begin
		n_ack = $urandom(32'h48b288ac);
		repeat (12) @(posedge clk);
		rst_n <= 1'b1;
		run_test(3'h4, 3);
		run_test(3'h6, 3);
		run_test(3'h3, 3);
		run_test(3'h5, 0);
		for (int i = 0; i < 3; i++)
			run_test(modes[$urandom % 3], 2);
		final_report();
	end
	// about seventeen times the expected run
	initial begin
		#1000000;
		n_errors++;
		final_report();
	end
endmodule
`default_nettype wire
